// ==== stc_cfg.svh ====
// Register offsets, field positions, reset values and timing figures of the timer/counter.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define STC_OFF_CTRL      8'h00
`define STC_OFF_GATE      8'h04
`define STC_OFF_CNT_LO    8'h08
`define STC_OFF_CNT_HI    8'h0C
`define STC_OFF_STATUS    8'h10
`define STC_OFF_MASK      8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STC_CTRL_CS_HI    7
`define STC_CTRL_CS_LO    6
`define STC_CTRL_PS_HI    5
`define STC_CTRL_PS_LO    4
`define STC_CTRL_OSCEN    3
`define STC_CTRL_SYNCDIS  2
`define STC_CTRL_ON       0
`define STC_CTRL_WMASK    8'hFD
`define STC_GATE_EN       7
`define STC_GATE_POL      6
`define STC_GATE_VAL      2
`define STC_GATE_CAPSEL   0
`define STC_GATE_WMASK    8'hC1
`define STC_OVF_BIT       0

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define STC_CTRL_RST      8'h00
`define STC_GATE_RST      8'h00
`define STC_CS_INST       2'b00
`define STC_CS_SYS        2'b01
`define STC_CS_EXT        2'b10
`define STC_CS_LFO        2'b11
`define STC_RESP_OKAY     2'b00
`define STC_RESP_SLVERR   2'b10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STC_SYS_PER_INST  2'd3
`define STC_CNT_MAX       16'hFFFF
`define STC_XTAL_HZ       32768

`endif

// ==== stc_pkg.sv ====
// Types shared by the timer/counter: bus carriers and the module state record.
package stc_pkg;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic [2:0]  awprot;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic [2:0]  arprot;
    logic        rready;
  } stc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stc_axi_rsp_s;

  // Pin sampling order: external clock, crystal, low-frequency osc, gate, capacitive osc.
  typedef struct packed {
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic [1:0]  phase;
    logic        pend;
    logic [7:0]  ctl;
    logic [7:0]  gcon;
    logic        ovf;
    logic        mask;
    logic [4:0]  sy1;
    logic [4:0]  sy2;
    logic        prev_src;
    logic        prev_lfo;
    logic        armed;
    logic        aw_got;
    logic [31:0] aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stc_state_s;

endpackage

// ==== stc_timer16.sv ====
// Sixteen-bit timer/counter with prescaler, clock selection, gate and AXI4-Lite registers.
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_timer16 #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire stc_pkg::stc_axi_req_s axi_req,
  output stc_pkg::stc_axi_rsp_s      axi_rsp,
  input  wire logic                  external_clock_pin,
  input  wire logic                  crystal_in_pin,
  input  wire logic                  low_freq_internal_osc,
  input  wire logic                  cap_sense_osc,
  input  wire logic                  gate_input_pin,
  input  wire logic                  sleep_mode,
  output logic                       crystal_osc_run,
  output logic                       irq
);
  import stc_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The highest register offset needs five address bits; more than the bus carries is void.
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32.");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // An address hits only when aligned, within the decoded window and listed.
  function automatic logic reg_hit(input logic [31:0] addr);
    logic [7:0] low;
    logic       upper_zero;
    low        = addr[7:0];
    upper_zero = (addr >> ADDR_W) == 32'h0000_0000;
    reg_hit = upper_zero && (
              low == `STC_OFF_CTRL   || low == `STC_OFF_GATE   ||
              low == `STC_OFF_CNT_LO || low == `STC_OFF_CNT_HI ||
              low == `STC_OFF_STATUS || low == `STC_OFF_MASK);
  endfunction

  // Last state of the prescale counter before it wraps, for each divide ratio.
  function automatic logic [2:0] prescale_last(input logic [1:0] ps);
    logic [2:0] res;
    unique case (ps)
      2'b00: res = 3'h0;
      2'b01: res = 3'h1;
      2'b10: res = 3'h3;
      2'b11: res = 3'h7;
    endcase
    prescale_last = res;
  endfunction

  // One packed record holds every flop; s_nxt is its combinational next value.
  stc_state_s s_r;
  stc_state_s s_nxt;

  // ----------------------------------------------------------------------
  // Derived view of the state
  // ----------------------------------------------------------------------
  logic [1:0] clock_source_field;
  logic [1:0] prescale_field;
  logic       timer_on_bit;
  logic       gate_enable_bit;
  logic       gate_polarity_bit;
  logic       crystal_osc_enable;
  logic       sync_disable_bit;
  logic       cap_sel;
  logic       ext_lvl;
  logic       xtal_lvl;
  logic       lfo_lvl;
  logic       gate_lvl;
  logic       cap_lvl;
  logic       src_lvl;
  logic       inst_tick;
  logic       ext_mode;
  logic       async_ext;
  logic       gate_ok;
  logic       run;
  logic       src_pulse;
  logic       pre_tick;
  logic       inc;
  logic       cnt_lo_wr;
  logic       cnt_hi_wr;
  logic       do_wr;
  logic       wr_hit;
  logic       ovf_set;
  logic       ovf_clr;
  logic [7:0] wr_low;
  logic [7:0] rd_low;
  logic [7:0] rd_val;

  // Control fields are plain slices of the stored register bytes.
  assign clock_source_field = s_r.ctl[`STC_CTRL_CS_HI:`STC_CTRL_CS_LO];
  assign prescale_field     = s_r.ctl[`STC_CTRL_PS_HI:`STC_CTRL_PS_LO];
  assign timer_on_bit       = s_r.ctl[`STC_CTRL_ON];
  assign crystal_osc_enable = s_r.ctl[`STC_CTRL_OSCEN];
  assign sync_disable_bit   = s_r.ctl[`STC_CTRL_SYNCDIS];
  assign gate_enable_bit    = s_r.gcon[`STC_GATE_EN];
  assign gate_polarity_bit  = s_r.gcon[`STC_GATE_POL];
  assign cap_sel            = s_r.gcon[`STC_GATE_CAPSEL];

  // Only the second synchroniser stage is ever read by logic.
  assign ext_lvl  = s_r.sy2[4];
  assign xtal_lvl = s_r.sy2[3];
  assign lfo_lvl  = s_r.sy2[2];
  assign gate_lvl = s_r.sy2[1];
  assign cap_lvl  = s_r.sy2[0];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // ------------------------------------------------------------------
    // Input synchronisers and instruction phase
    // ------------------------------------------------------------------
    // Pins are foreign to aclk and always pass two flip-flops first.
    s_nxt.sy1 = {external_clock_pin, crystal_in_pin, low_freq_internal_osc,
                 gate_input_pin, cap_sense_osc};
    s_nxt.sy2 = s_r.sy1;

    // Four system clocks make one instruction cycle.
    // The phase runs freely from reset; register writes never restart it.
    s_nxt.phase = s_r.phase + 2'd1;
    inst_tick   = s_r.phase == `STC_SYS_PER_INST;

    // ------------------------------------------------------------------
    // Clock source selection and edge arming
    // ------------------------------------------------------------------
    // Changing the source while running can show a false edge; stop the timer first.
    // The crystal takes priority over the pin whenever its oscillator is enabled.
    // External counter source: crystal when enabled, else pin or capacitive osc.
    if (crystal_osc_enable) begin
      src_lvl = xtal_lvl;
    end else if (cap_sel) begin
      src_lvl = cap_lvl;
    end else begin
      src_lvl = ext_lvl;
    end
    s_nxt.prev_src = src_lvl;
    s_nxt.prev_lfo = lfo_lvl;

    ext_mode  = clock_source_field == `STC_CS_EXT;
    async_ext = ext_mode && sync_disable_bit;

    // The gate is seen two cycles late through its synchroniser; pulses shorter than one aclk cycle can be lost.
    gate_ok = !gate_enable_bit || (gate_lvl == gate_polarity_bit);
    // In Sleep the core clocks stop, so only the unsynchronised external path counts.
    run     = timer_on_bit && gate_ok && (!sleep_mode || async_ext);

    // The low-frequency oscillator runs freely and needs no arming.
    unique case (clock_source_field)
      `STC_CS_INST: src_pulse = inst_tick;
      `STC_CS_SYS:  src_pulse = 1'b1;
      `STC_CS_EXT:  src_pulse = src_lvl && !s_r.prev_src && s_r.armed;
      `STC_CS_LFO:  src_pulse = lfo_lvl && !s_r.prev_lfo;
    endcase

    // Dropping the arm on disable keeps the first rise of a pin that is low at re-enable from counting.
    // Counter mode needs a falling edge after enable, count byte write or disable.
    if (!timer_on_bit) begin
      s_nxt.armed = 1'b0;
    end else if (!src_lvl && s_r.prev_src) begin
      s_nxt.armed = 1'b1;
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // The prescale count moves only on accepted source pulses and count byte writes, so a gated or idle
    // source leaves the division phase where it was.
    pre_tick = 1'b0;
    if (run && src_pulse) begin
      if (s_r.pre >= prescale_last(prescale_field)) begin
        s_nxt.pre = 3'h0;
        pre_tick  = 1'b1;
      end else begin
        s_nxt.pre = s_r.pre + 3'h1;
      end
    end

    // ------------------------------------------------------------------
    // Count enable and synchronisation
    // ------------------------------------------------------------------
    // Async mode counts a tick at once; sync mode holds it until the phase boundary.
    // Synchronised external ticks wait for the next instruction phase boundary.
    // Dropping a pending tick on the switch to async costs one increment.
    inc = 1'b0;
    if (ext_mode && !sync_disable_bit) begin
      if (pre_tick) begin
        s_nxt.pend = 1'b1;
      end
      if ((s_r.pend || pre_tick) && inst_tick) begin
        inc        = 1'b1;
        s_nxt.pend = 1'b0;
      end
    end else begin
      inc        = pre_tick;
      s_nxt.pend = 1'b0;
    end

    // ------------------------------------------------------------------
    // Counter and overflow
    // ------------------------------------------------------------------
    ovf_set = 1'b0;
    if (inc) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
      ovf_set   = s_r.cnt == `STC_CNT_MAX;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data are held apart so the master may offer them in either order.
    axi_rsp.awready = !s_r.aw_got && !s_r.bvalid;
    axi_rsp.wready  = !s_r.w_got && !s_r.bvalid;
    if (axi_req.awvalid && axi_rsp.awready) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      s_nxt.w_got   = 1'b1;
      s_nxt.w_data  = axi_req.wdata[7:0];
      s_nxt.w_lane0 = axi_req.wstrb[0];
    end

    // The write lands a cycle after both halves are held, keeping decode off the ready path.
    do_wr     = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_hit    = reg_hit(s_r.aw_addr);
    wr_low    = s_r.aw_addr[7:0];
    cnt_lo_wr = do_wr && wr_hit && s_r.w_lane0 && wr_low == `STC_OFF_CNT_LO;
    cnt_hi_wr = do_wr && wr_hit && s_r.w_lane0 && wr_low == `STC_OFF_CNT_HI;
    ovf_clr   = 1'b0;

    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wr_hit ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
      if (wr_hit && s_r.w_lane0) begin
        unique case (wr_low)
          `STC_OFF_CTRL: s_nxt.ctl = s_r.w_data & `STC_CTRL_WMASK;
          `STC_OFF_GATE: s_nxt.gcon = s_r.w_data & `STC_GATE_WMASK;
          `STC_OFF_STATUS: ovf_clr = s_r.w_data[`STC_OVF_BIT];
          `STC_OFF_MASK: s_nxt.mask = s_r.w_data[`STC_OVF_BIT];
          default: ;
        endcase
      end
    end
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // ------------------------------------------------------------------
    // Count byte writes
    // ------------------------------------------------------------------
    // Bytes are written one at a time, so a running count can carry between two writes.
    // A byte write overrides its own byte of a same-cycle increment and restarts the prescaler.
    if (cnt_lo_wr) begin
      s_nxt.cnt[7:0] = s_r.w_data;
    end
    if (cnt_hi_wr) begin
      s_nxt.cnt[15:8] = s_r.w_data;
    end
    if (cnt_lo_wr || cnt_hi_wr) begin
      s_nxt.pre   = 3'h0;
      s_nxt.pend  = 1'b0;
      s_nxt.armed = 1'b0;
      ovf_set     = 1'b0;
    end

    // The flag is sticky: only a one written to the status bit clears it.
    // Hardware set wins over a same-cycle write-one-to-clear.
    s_nxt.ovf = ovf_set || (s_r.ovf && !ovf_clr);

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    axi_rsp.arready = !s_r.rvalid;
    rd_low          = axi_req.araddr[7:0];
    // Count bytes are read live; a carry between two byte reads is visible to software.
    unique case (rd_low)
      `STC_OFF_CTRL: rd_val = s_r.ctl;
      `STC_OFF_GATE: rd_val = {s_r.gcon[7:3], gate_lvl, s_r.gcon[1:0]};
      `STC_OFF_CNT_LO: rd_val = s_r.cnt[7:0];
      `STC_OFF_CNT_HI: rd_val = s_r.cnt[15:8];
      `STC_OFF_STATUS: rd_val = {7'h00, s_r.ovf};
      `STC_OFF_MASK: rd_val = {7'h00, s_r.mask};
      default: rd_val = 8'h00;
    endcase
    // Read data are captured at acceptance and frozen until the master takes them.
    if (axi_req.arvalid && axi_rsp.arready) begin
      s_nxt.rvalid = 1'b1;
      if (reg_hit(axi_req.araddr)) begin
        s_nxt.rdata = {24'h00_0000, rd_val};
        s_nxt.rresp = `STC_RESP_OKAY;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = `STC_RESP_SLVERR;
      end
    end
    if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Response payloads come straight from flops.
    axi_rsp.bvalid = s_r.bvalid;
    axi_rsp.bresp  = s_r.bresp;
    axi_rsp.rvalid = s_r.rvalid;
    axi_rsp.rdata  = s_r.rdata;
    axi_rsp.rresp  = s_r.rresp;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Control words restate their reset constants so a change to them stays local.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r      <= '0;
      s_r.ctl  <= `STC_CTRL_RST;
      s_r.gcon <= `STC_GATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The oscillator enable ignores Sleep so a crystal time base survives it.
  assign crystal_osc_run = crystal_osc_enable;
  // The level interrupt doubles as the Sleep wake request.
  assign irq = s_r.ovf && s_r.mask;

endmodule // stc_timer16

// ==== stc_timer16_checker.sv ====
// Concurrent checks on the timer/counter ports.
`timescale 1ns/1ps

module stc_timer16_checker (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire stc_pkg::stc_axi_req_s axi_req,
  input wire stc_pkg::stc_axi_rsp_s axi_rsp,
  input wire logic                  crystal_osc_run,
  input wire logic                  irq
);
  import stc_pkg::*;

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_AR_ANS: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer missing");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write answer dropped");
  AST_B_LAT: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid &&
    axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  AST_B_REF: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken during answer");
  AST_AW_REF: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("second address taken");
  AST_HI_ZERO: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");

  // ----------------------------------------------------------------------
  // Outputs that only software may change (oscillator run) or clear (interrupt)
  // ----------------------------------------------------------------------
  // Sleep has no input here on purpose: the oscillator must ignore it.
  AST_OSC_RUN: assert property ($changed(crystal_osc_run) |-> $rose(axi_rsp.bvalid))
    else $error("oscillator run changed without a write");
  AST_IRQ_CLR: assert property ($fell(irq) |-> $rose(axi_rsp.bvalid))
    else $error("interrupt cleared without a write");

  COV_IRQ: cover property ($rose(irq));
  COV_ERR: cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'b10);
  COV_OSC: cover property ($rose(crystal_osc_run));
endmodule // stc_timer16_checker

bind stc_timer16 stc_timer16_checker i_stc_timer16_checker (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .crystal_osc_run(crystal_osc_run), .irq(irq));

// ==== stc_ext_src.sv ====
// Far-side model: external count clock and gate signal.
`timescale 1ns/1ps

module stc_ext_src (
  input wire logic aclk,
  output logic     ext_clk,
  output logic     gate
);
  // The clock idles low between bursts, so the first rise of a burst has no fall before it.
  initial begin
    ext_clk = 1'b0;
    gate = 1'b0;
  end

  task automatic pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge aclk);
      ext_clk <= 1'b1;
      repeat (half) @(posedge aclk);
      ext_clk <= 1'b0;
    end
  endtask

  task automatic set_gate(input logic lvl);
    @(posedge aclk);
    gate <= lvl;
  endtask
endmodule // stc_ext_src

// ==== stc_timer16_tb.sv ====
// Self-checking testbench for the timer/counter.
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_timer16_tb;
  import stc_pkg::*;

  logic         aclk = 1'b0;
  logic         aresetn;
  stc_axi_req_s req;
  stc_axi_rsp_s rsp;
  logic         ext_clk;
  logic         gate;
  logic         sleep_mode;
  logic         crystal_osc_run;
  logic         irq;
  int           n_fail = 0;
  int           checks = 0;

  always #10 aclk = ~aclk;

  stc_ext_src i_stc_ext_src (.aclk(aclk), .ext_clk(ext_clk), .gate(gate));

  stc_timer16 i_stc_timer16 (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .external_clock_pin(ext_clk), .crystal_in_pin(ext_clk),
    .low_freq_internal_osc(ext_clk), .cap_sense_osc(ext_clk), .gate_input_pin(gate),
    .sleep_mode(sleep_mode), .crystal_osc_run(crystal_osc_run), .irq(irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.awaddr <= 32'(a);
    req.wdata <= 32'(d);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    req.araddr <= 32'(a);
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    req.rready <= 1'b0;
  endtask

  // Counts from zero for a window of w + 4 cycles, or 16p + 4 if that is longer, while p source pulses arrive.
  task automatic run(input logic [7:0] c, input int w, input int p, output logic [15:0] n);
    logic [31:0] h;
    logic [31:0] l;
    logic [1:0]  r;
    wr(`STC_OFF_CTRL, 8'h00, r);
    wr(`STC_OFF_CNT_LO, 8'h00, r);
    wr(`STC_OFF_CNT_HI, 8'h00, r);
    wr(`STC_OFF_CTRL, c, r);
    fork
      repeat (w) @(posedge aclk);
      i_stc_ext_src.pulses(p, 8);
    join
    wr(`STC_OFF_CTRL, 8'h00, r);
    rd(`STC_OFF_CNT_HI, h);
    rd(`STC_OFF_CNT_LO, l);
    n = {h[7:0], l[7:0]};
  endtask

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0]  offs [6] = '{`STC_OFF_CTRL, `STC_OFF_GATE, `STC_OFF_CNT_LO,
                              `STC_OFF_CNT_HI, `STC_OFF_STATUS, `STC_OFF_MASK};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (offs[i]) begin
      rd(offs[i], d);
      check(d, 32'h0000_0000);
    end
    wr(8'h18, 8'hFF, r);
    check(32'(r), 32'(`STC_RESP_SLVERR));
    rd(8'h18, d);
    check(d, 32'h0000_0000);
    check(32'(rsp.rresp), 32'(`STC_RESP_SLVERR));
    wr(`STC_OFF_CTRL, 8'hFE, r);
    rd(`STC_OFF_CTRL, d);
    check(d, 32'h0000_00FC);
    sleep_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'(crystal_osc_run), 32'h1);
    sleep_mode <= 1'b0;
    i_stc_ext_src.set_gate(1'b1);
    wr(`STC_OFF_GATE, 8'hFF, r);
    rd(`STC_OFF_GATE, d);
    check(d, 32'h0000_00C5);
    i_stc_ext_src.set_gate(1'b0);
    wr(`STC_OFF_GATE, 8'h00, r);
    wr(`STC_OFF_CTRL, 8'h00, r);
    $display("t_regs done");
  endtask

  task automatic t_rate();
    logic [7:0]  c [5] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41};
    int          e [5] = '{64, 32, 16, 8, 256};
    logic [15:0] n;
    foreach (c[i]) begin
      run(c[i], 252, 0, n);
      // The timer is on for exactly w + 4 clocks, a multiple of four, whatever the phase.
      check(32'(n), 32'(e[i]));
    end
    $display("t_rate done");
  endtask

  task automatic t_ovf();
    logic [31:0] d;
    logic [1:0]  r;
    // Start-up wait: preload FC00h and let 1024 system clocks roll it over.
    wr(`STC_OFF_STATUS, 8'h01, r);
    wr(`STC_OFF_CNT_LO, 8'h00, r);
    wr(`STC_OFF_CNT_HI, 8'hFC, r);
    wr(`STC_OFF_CTRL, 8'h41, r);
    repeat (1020) @(posedge aclk);
    wr(`STC_OFF_CTRL, 8'h00, r);
    rd(`STC_OFF_STATUS, d);
    check(d, 32'h0000_0001);
    check(32'(irq), 32'h0);
    wr(`STC_OFF_MASK, 8'h01, r);
    check(32'(irq), 32'h1);
    wr(`STC_OFF_STATUS, 8'h01, r);
    check(32'(irq), 32'h0);
    rd(`STC_OFF_CNT_HI, d);
    check(d, 32'h0000_0000);
    rd(`STC_OFF_CNT_LO, d);
    check(d, 32'h0000_0000);
    $display("t_ovf done");
  endtask

  task automatic t_ext();
    logic [7:0]  c [8] = '{8'h85, 8'h89, 8'h85, 8'h85, 8'h85, 8'h84, 8'hC1, 8'h85};
    logic [7:0]  g [8] = '{8'h00, 8'h00, 8'h00, 8'hC0, 8'hC0, 8'h00, 8'h00, 8'h01};
    logic        s [8] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic        p [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    int          e [8] = '{4, 4, 4, 0, 4, 0, 5, 4};
    logic [15:0] n;
    logic [1:0]  r;
    foreach (c[i]) begin
      wr(`STC_OFF_GATE, g[i], r);
      i_stc_ext_src.set_gate(p[i]);
      sleep_mode <= s[i];
      run(c[i], 96, 5, n);
      check(32'(n), 32'(e[i]));
    end
    sleep_mode <= 1'b0;
    $display("t_ext done");
  endtask

  initial begin
    req = '0;
    req.wstrb = 4'hF;
    aresetn = 1'b0;
    sleep_mode = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rate();
    t_ovf();
    t_ext();
    print_verdict();
  end

  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end
endmodule // stc_timer16_tb
